// file: idc_map.vh
// Opcode, field and clock-count constants for the instruction decode timing block.
`ifndef IDC_MAP_VH
`define IDC_MAP_VH
// ==========================================
// Opcodes
`define IDC_OP_GRP_F    8'hF6
`define IDC_OP_GRP_INC  8'hFE
`define IDC_OP_ESC      8'h0F
`define IDC_OP_MUL2     8'hAF
`define IDC_OP_MULI     8'h69
`define IDC_OP_IN_FIX   8'hE4
`define IDC_OP_IN_VAR   8'hEC
`define IDC_OP_INC_S    8'h40
`define IDC_OP_STR_IN   8'h6C
`define IDC_OP_INT      8'hCD
`define IDC_REG_MUL     3'h5
`define IDC_REG_INC     3'h0
// ==========================================
// Clock counts
`define IDC_CC_MUL_S    7'h04
`define IDC_CC_MUL_D    7'h0A
`define IDC_CC_MULI_W   7'h05
`define IDC_CC_MULI_D   7'h0B
`define IDC_CC_IO       7'h0E
`define IDC_CC_IO_PRIV  7'h1C
`define IDC_CC_INC      7'h01
`define IDC_CC_INT_R    7'h09
`define IDC_CC_INT_SAME 7'h15
`define IDC_CC_INT_DIFF 7'h20
`define IDC_CC_TG_1616  7'h72
`define IDC_CC_TG_1632  7'h7A
`define IDC_CC_TG_3232  7'h7C
`define IDC_CC_TG_16V   7'h64
`define IDC_CC_TG_32V   7'h66
`define IDC_CC_V_16     7'h7C
`define IDC_CC_V_32     7'h66
`define IDC_CC_V_P0     7'h2E
`define IDC_CC_OTHER    7'h01
// ==========================================
// Instruction classes
`define IDC_CL_NONE     4'h0
`define IDC_CL_MUL_ACC  4'h1
`define IDC_CL_MUL_REG  4'h2
`define IDC_CL_MUL_IMM  4'h3
`define IDC_CL_IN_FIX   4'h4
`define IDC_CL_IN_VAR   4'h5
`define IDC_CL_INC      4'h6
`define IDC_CL_STR_IN   4'h7
`define IDC_CL_INT      4'h8
// ==========================================
// Interrupt delivery kinds
`define IDC_DV_SAME     3'h0
`define IDC_DV_DIFF     3'h1
`define IDC_DV_TG_16    3'h2
`define IDC_DV_TG_32    3'h3
`define IDC_DV_TG_V86   3'h4
`define IDC_DV_V86_GATE 3'h5
`endif

// file: idc_count.v
// Clock-count countdown that holds an instruction busy for its execution time.
`timescale 1ns/1ps
module idc_count #(
  parameter W = 7
) (
  input  wire         ref_clk,
  input  wire         sys_rst,
  input  wire         load,
  input  wire [W-1:0] count,
  output wire         busy,
  output reg          done
);
  reg [W-1:0] rem_q;

  assign busy = (rem_q != {W{1'b0}});

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rem_q <= {W{1'b0}};
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        rem_q <= count;
      end else if (busy) begin
        rem_q <= rem_q - {{(W-1){1'b0}}, 1'b1};
        if (rem_q == {{(W-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule // idc_count

// file: idc_decode.v
// Instruction decoder that classifies five instruction groups and times their execution.
`timescale 1ns/1ps
`include "idc_map.vh"
module idc_decode (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        insn_valid,
  input  wire [7:0]  insn_b0,
  input  wire [7:0]  insn_b1,
  input  wire [7:0]  insn_b2,
  input  wire        op32,
  input  wire        addr32,
  input  wire        prot_mode,
  input  wire        v86_mode,
  input  wire        io_priv_fail,
  input  wire [2:0]  int_delivery,
  input  wire        task_src32,
  input  wire        task_dst32,
  output wire        insn_ready,
  output reg         dec_valid,
  output reg  [3:0]  dec_class,
  output reg         dec_byte_op,
  output reg  [6:0]  dec_clocks,
  output reg  [5:0]  dec_imm_bits,
  output reg  [5:0]  dec_disp_bits,
  output reg  [2:0]  dec_reg,
  output reg  [7:0]  dec_vector,
  output reg         dec_keep_carry,
  output reg         dec_clear_flag,
  output wire        exec_busy,
  output wire        exec_done
);
  // ==========================================
  // Combinational decode
  reg  [3:0] cls_d;
  reg  [6:0] clk_d;
  reg        byte_d;
  reg  [5:0] imm_d;
  reg  [5:0] disp_d;
  reg  [2:0] reg_d;
  reg  [7:0] vec_d;
  reg        keep_d;
  reg        clr_d;
  reg  [6:0] int_clk;
  reg  [6:0] int_pm_clk;
  reg  [6:0] int_v86_clk;

  // ==========================================
  // Operand fields
  // The two-byte multiply carries its ModRM byte one place later, so the field source follows the escape byte.
  wire       two_byte  = (insn_b0 == `IDC_OP_ESC);
  wire [7:0] modrm     = two_byte ? insn_b2 : insn_b1;
  wire [2:0] modrm_reg = modrm[5:3];
  wire [1:0] modrm_mod = modrm[7:6];
  wire [2:0] modrm_rm  = modrm[2:0];
  wire       w_bit     = insn_b0[0];
  wire [5:0] full_imm  = op32 ? 6'h20 : 6'h10;
  wire [5:0] full_disp = addr32 ? 6'h20 : 6'h10;
  wire [2:0] disp_only = addr32 ? 3'h5 : 3'h6;
  wire [6:0] io_clk    = (prot_mode && io_priv_fail) ? `IDC_CC_IO_PRIV : `IDC_CC_IO;

  // ==========================================
  // Opcode match
  // Group matches stand apart from the priority chain so each opcode pattern reads as it is encoded.
  wire       m_mul_acc = ({insn_b0[7:1], 1'b0} == `IDC_OP_GRP_F) && (modrm_reg == `IDC_REG_MUL);
  wire       m_inc_grp = ({insn_b0[7:1], 1'b0} == `IDC_OP_GRP_INC) && (modrm_reg == `IDC_REG_INC);
  wire       m_mul_reg = two_byte && (insn_b1 == `IDC_OP_MUL2);
  wire       m_mul_imm = ({insn_b0[7:2], 1'b0, insn_b0[0]} == `IDC_OP_MULI);
  wire       m_in_fix  = ({insn_b0[7:1], 1'b0} == `IDC_OP_IN_FIX);
  wire       m_in_var  = ({insn_b0[7:1], 1'b0} == `IDC_OP_IN_VAR);
  wire       m_inc_s   = ({insn_b0[7:3], 3'h0} == `IDC_OP_INC_S);
  wire       m_str_in  = ({insn_b0[7:1], 1'b0} == `IDC_OP_STR_IN);
  wire       m_int     = (insn_b0 == `IDC_OP_INT);
  wire       has_modrm = m_mul_acc || m_inc_grp || m_mul_reg || m_mul_imm;

  // ==========================================
  // Interrupt timing
  // The count depends on the kind of gate the delivery resolved to.
  always @* begin
    case (int_delivery)
      `IDC_DV_TG_16: int_v86_clk = `IDC_CC_V_16;
      `IDC_DV_TG_32: int_v86_clk = `IDC_CC_V_32;
      default:       int_v86_clk = `IDC_CC_V_P0;
    endcase
  end

  always @* begin
    case (int_delivery)
      `IDC_DV_SAME:   int_pm_clk = `IDC_CC_INT_SAME;
      `IDC_DV_DIFF:   int_pm_clk = `IDC_CC_INT_DIFF;
      `IDC_DV_TG_16:  int_pm_clk = task_src32 ? `IDC_CC_TG_3232 : `IDC_CC_TG_1616;
      `IDC_DV_TG_32:  int_pm_clk = task_src32 ? `IDC_CC_TG_3232 : `IDC_CC_TG_1632;
      `IDC_DV_TG_V86: int_pm_clk = task_src32 ? `IDC_CC_TG_32V : `IDC_CC_TG_16V;
      default:        int_pm_clk = `IDC_CC_INT_SAME;
    endcase
  end

  // Virtual-8086 mode wins over the protected-mode flag, since both are set while it runs.
  always @* begin
    int_clk = `IDC_CC_INT_R;
    if (v86_mode) begin
      int_clk = int_v86_clk;
    end else if (prot_mode) begin
      int_clk = int_pm_clk;
    end
  end

  // ==========================================
  // Instruction class
  always @* begin
    cls_d  = `IDC_CL_NONE;
    clk_d  = `IDC_CC_OTHER;
    byte_d = ~w_bit;
    imm_d  = 6'h00;
    reg_d  = modrm_reg;
    vec_d  = 8'h00;
    keep_d = 1'b0;
    clr_d  = 1'b0;
    if (m_mul_acc) begin
      cls_d = `IDC_CL_MUL_ACC;
      clk_d = (w_bit && op32) ? `IDC_CC_MUL_D : `IDC_CC_MUL_S;
    end else if (m_inc_grp) begin
      cls_d  = `IDC_CL_INC;
      clk_d  = `IDC_CC_INC;
      keep_d = 1'b1;
    end else if (m_mul_reg) begin
      cls_d  = `IDC_CL_MUL_REG;
      byte_d = 1'b0;
      clk_d  = op32 ? `IDC_CC_MUL_D : `IDC_CC_MUL_S;
    end else if (m_mul_imm) begin
      cls_d  = `IDC_CL_MUL_IMM;
      byte_d = 1'b0;
      imm_d  = insn_b0[1] ? 6'h08 : full_imm;
      clk_d  = op32 ? `IDC_CC_MULI_D : `IDC_CC_MULI_W;
    end else if (m_in_fix) begin
      cls_d = `IDC_CL_IN_FIX;
      imm_d = 6'h08;
      clk_d = io_clk;
    end else if (m_in_var) begin
      cls_d = `IDC_CL_IN_VAR;
      clk_d = io_clk;
    end else if (m_inc_s) begin
      cls_d  = `IDC_CL_INC;
      byte_d = 1'b0;
      clk_d  = `IDC_CC_INC;
      reg_d  = insn_b0[2:0];
      keep_d = 1'b1;
    end else if (m_str_in) begin
      cls_d = `IDC_CL_STR_IN;
      clk_d = io_clk;
    end else if (m_int) begin
      cls_d  = `IDC_CL_INT;
      byte_d = 1'b0;
      imm_d  = 6'h08;
      clk_d  = int_clk;
      vec_d  = insn_b1;
      clr_d  = 1'b1;
    end
  end

  // ==========================================
  // Displacement size
  // SIB bytes are not examined, so a based form with a SIB byte reports the ModRM displacement only.
  always @* begin
    disp_d = 6'h00;
    if (has_modrm) begin
      if (modrm_mod == 2'h1) begin
        disp_d = 6'h08;
      end else if (modrm_mod == 2'h2 || (modrm_mod == 2'h0 && modrm_rm == disp_only)) begin
        disp_d = full_disp;
      end
    end
  end

  // ==========================================
  // Issue and timing
  // A new instruction is refused while the previous one is still counting down.
  wire take = insn_valid && !exec_busy;
  assign insn_ready = !exec_busy;

  idc_count #(
    .W (7)
  ) u_count (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (take),
    .count   (clk_d),
    .busy    (exec_busy),
    .done    (exec_done)
  );

  // ==========================================
  // Decoded fields
  // Fields other than dec_valid load only on a take, so they stand until the next accepted instruction; dec_valid follows take every cycle.

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      dec_valid      <= 1'b0;
      dec_class      <= `IDC_CL_NONE;
      dec_byte_op    <= 1'b0;
      dec_clocks     <= 7'h00;
      dec_imm_bits   <= 6'h00;
      dec_disp_bits  <= 6'h00;
      dec_reg        <= 3'h0;
      dec_vector     <= 8'h00;
      dec_keep_carry <= 1'b0;
      dec_clear_flag <= 1'b0;
    end else begin
      dec_valid <= take;
      if (take) begin
        dec_class      <= cls_d;
        dec_byte_op    <= byte_d;
        dec_clocks     <= clk_d;
        dec_imm_bits   <= imm_d;
        dec_disp_bits  <= disp_d;
        dec_reg        <= reg_d;
        dec_vector     <= vec_d;
        dec_keep_carry <= keep_d;
        dec_clear_flag <= clr_d;
      end
    end
  end
endmodule // idc_decode

// file: idc_chk_sva.sv
// Concurrent checks on the ports of the instruction decode timing block.
`timescale 1ns/1ps
module idc_chk (
  input wire       ref_clk,
  input wire       sys_rst,
  input wire [7:0] insn_b0,
  input wire       op32,
  input wire       prot_mode,
  input wire       v86_mode,
  input wire       dec_valid,
  input wire [3:0] dec_class,
  input wire       dec_byte_op,
  input wire [6:0] dec_clocks,
  input wire       dec_keep_carry,
  input wire       dec_clear_flag,
  input wire       exec_busy,
  input wire       exec_done
);
  // ==========================================
  // Properties
  // Inputs only change between transfers, so a one-deep past sees the taken values.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_busy4; exec_busy [*4] ##1 (exec_done && !exec_busy); endsequence
  sequence s_busy1; exec_busy ##1 (exec_done && !exec_busy); endsequence
  property p_mul; dec_valid && dec_class inside {4'h1, 4'h2} |->
    dec_clocks == ((!dec_byte_op && $past(op32)) ? 7'h0A : 7'h04); endproperty
  a_mul: assert property (p_mul) else $error("multiply count wrong");
  property p_muli; dec_valid && dec_class == 4'h3 |-> dec_clocks == ($past(op32) ? 7'h0B : 7'h05); endproperty
  a_muli: assert property (p_muli) else $error("immediate multiply count wrong");
  property p_io; dec_valid && dec_class inside {4'h4, 4'h5, 4'h7} |-> dec_clocks inside {7'h0E, 7'h1C}; endproperty
  a_io: assert property (p_io) else $error("port input count wrong");
  property p_inc; dec_valid && dec_class == 4'h6 |-> dec_clocks == 7'h01 && dec_keep_carry; endproperty
  a_inc: assert property (p_inc) else $error("increment decode wrong");
  property p_int; dec_valid && dec_class == 4'h8 && !$past(prot_mode) && !$past(v86_mode) |->
    dec_clocks == 7'h09 && dec_clear_flag; endproperty
  a_int: assert property (p_int) else $error("real mode interrupt wrong");
  property p_len4; dec_valid && dec_clocks == 7'h04 |-> s_busy4; endproperty
  a_len4: assert property (p_len4) else $error("four clock hold wrong");
  property p_len1; dec_valid && dec_clocks == 7'h01 |-> s_busy1; endproperty
  a_len1: assert property (p_len1) else $error("one clock hold wrong");
  property p_byte; dec_valid && $past(insn_b0) == 8'hF6 |-> dec_byte_op; endproperty
  a_byte: assert property (p_byte) else $error("byte operand flag wrong");
endmodule // idc_chk

// file: tb_insn_decode_clock_counts.sv
// Self-checking testbench for the instruction decode timing block.
`timescale 1ns/1ps
module tb_insn_decode_clock_counts;
  reg        ref_clk = 0, sys_rst = 1, iv = 0, op32 = 0, a32 = 0, pm = 0, v86 = 0, iof = 0, ts = 0;
  reg  [7:0] b0 = 0, b1 = 0, b2 = 0;
  reg  [2:0] dv = 0;
  wire       rdy, dval, bop, kc, cf, busy, done;
  wire [3:0] cls;
  wire [6:0] cnt;
  wire [5:0] ib, db;
  wire [2:0] rg;
  wire [7:0] vec;
  int        fails = 0, checks = 0;
  idc_decode i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .insn_valid(iv), .insn_b0(b0), .insn_b1(b1),
    .insn_b2(b2), .op32(op32), .addr32(a32), .prot_mode(pm), .v86_mode(v86), .io_priv_fail(iof),
    .int_delivery(dv), .task_src32(ts), .task_dst32(1'b0), .insn_ready(rdy), .dec_valid(dval),
    .dec_class(cls), .dec_byte_op(bop), .dec_clocks(cnt), .dec_imm_bits(ib), .dec_disp_bits(db),
    .dec_reg(rg), .dec_vector(vec), .dec_keep_carry(kc), .dec_clear_flag(cf), .exec_busy(busy),
    .exec_done(done));
  // ==========================================
  // Shared tasks
  initial forever #5 ref_clk = ~ref_clk;
  task automatic end_of_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Busy is counted at falling edges, so the count equals the held clocks exactly.
  task automatic run(input [7:0] a, input [7:0] b, input [7:0] m, input [3:0] c, input [6:0] n);
    int k;
    @(negedge ref_clk);
    b0 = a; b1 = b; b2 = m; iv = 1;
    @(negedge ref_clk);
    iv = 0;
    chk(dval, 8'h01); chk(cls, c); chk(cnt, n); chk(rdy, 8'h00);
    k = 0;
    while (busy === 1'b1 && k < 200) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 200) begin
      fails++;
      end_of_test;
    end
    chk(k, n); chk(done, 8'h01);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_mul;
    op32 = 0; run(8'hF6, 8'hE8, 8'h00, 4'h1, 7'h04); chk(bop, 8'h01);
    op32 = 1; run(8'hF7, 8'hE8, 8'h00, 4'h1, 7'h0A); chk(bop, 8'h00);
    run(8'h0F, 8'hAF, 8'hC0, 4'h2, 7'h0A); chk(db, 8'h00);
    op32 = 0; run(8'h0F, 8'hAF, 8'h45, 4'h2, 7'h04); chk(db, 8'h08); chk(rg, 8'h00);
    run(8'h69, 8'h80, 8'h00, 4'h3, 7'h05); chk(ib, 8'h10); chk(db, 8'h10);
    op32 = 1; a32 = 1; run(8'h69, 8'h80, 8'h00, 4'h3, 7'h0B); chk(ib, 8'h20); chk(db, 8'h20);
    run(8'h6B, 8'h40, 8'h00, 4'h3, 7'h0B); chk(ib, 8'h08); chk(db, 8'h08);
    op32 = 0; a32 = 0;
  endtask
  task automatic t_io;
    run(8'hE4, 8'h60, 8'h00, 4'h4, 7'h0E); chk(ib, 8'h08); pm = 1; iof = 1;
    run(8'hEC, 8'h00, 8'h00, 4'h5, 7'h1C); run(8'h6D, 8'h00, 8'h00, 4'h7, 7'h1C); iof = 0;
    run(8'h6C, 8'h00, 8'h00, 4'h7, 7'h0E); run(8'hE5, 8'h60, 8'h00, 4'h4, 7'h0E); pm = 0;
  endtask
  task automatic t_inc;
    for (int r = 0; r < 8; r++) begin
      run(8'h40 + r, 8'h00, 8'h00, 4'h6, 7'h01); chk(kc, 8'h01); chk(rg, r);
    end
    run(8'hFF, 8'hC0, 8'h00, 4'h6, 7'h01); run(8'hFE, 8'hC0, 8'h00, 4'h6, 7'h01);
  endtask
  task automatic t_int;
    logic [6:0] n [10] = '{7'h15, 7'h20, 7'h72, 7'h7A, 7'h64, 7'h7C, 7'h66, 7'h7C, 7'h66, 7'h2E};
    logic [2:0] d [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h2, 3'h3, 3'h5};
    run(8'hCD, 8'h5A, 8'h00, 4'h8, 7'h09); chk(vec, 8'h5A); chk(cf, 8'h01); pm = 1;
    for (int i = 0; i < 10; i++) begin
      dv = d[i]; ts = (i == 5 || i == 6); v86 = (i > 6);
      run(8'hCD, i, 8'h00, 4'h8, n[i]); chk(vec, i);
    end
  endtask
  // A request held while busy must wait out the countdown and then be taken once.
  task automatic t_refuse;
    @(negedge ref_clk);
    pm = 0; v86 = 0; b0 = 8'hCD; b1 = 8'h33; iv = 1;
    @(negedge ref_clk);
    b0 = 8'h41; b1 = 8'h00;
    repeat (8) begin
      @(negedge ref_clk);
      chk(dval, 8'h00); chk(rdy, 8'h00); chk(cls, 8'h08);
    end
    @(negedge ref_clk);
    chk(rdy, 8'h01); chk(done, 8'h01);
    @(negedge ref_clk);
    iv = 0;
    chk(dval, 8'h01); chk(cls, 8'h06); chk(rg, 8'h01);
    @(negedge ref_clk);
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 0;
    chk(rdy, 8'h01); chk(dval, 8'h00);
    t_mul; t_io; t_inc; t_int; t_refuse;
    end_of_test;
  end
endmodule // tb_insn_decode_clock_counts
bind idc_decode idc_chk i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .insn_b0(insn_b0), .op32(op32),
  .prot_mode(prot_mode), .v86_mode(v86_mode), .dec_valid(dec_valid), .dec_class(dec_class),
  .dec_byte_op(dec_byte_op), .dec_clocks(dec_clocks), .dec_keep_carry(dec_keep_carry),
  .dec_clear_flag(dec_clear_flag), .exec_busy(exec_busy), .exec_done(exec_done));
